// *** hw/chain_pkg.sv ***
// Shared constants and carriers for the chained converter serial readout
package chain_pkg;
	localparam int NUM_CH      = 8;
	localparam int STATUS_BITS = 24;
	localparam int RES_HI      = 24;
	localparam int RES_LO      = 16;
	localparam int FRAME_HI    = NUM_CH * RES_HI + STATUS_BITS;
	localparam int FRAME_LO    = NUM_CH * RES_LO + STATUS_BITS;
	// Own frame plus the single don't-care bit ahead of downstream data
	localparam int SR_LEN      = FRAME_HI + 1;
	localparam int CMD_BITS    = 8;
	localparam int REG_BITS    = 8;
	localparam int DELAY_W     = 16;
	localparam int BITS_W      = 8;
	// Data-rate codes at or above this value run at full resolution
	localparam logic [2:0] DR_HI_RES_MIN = 3'h2;
	localparam logic [BITS_W-1:0] FRAME_HI_BITS = BITS_W'(FRAME_HI);
	localparam logic [BITS_W-1:0] FRAME_LO_BITS = BITS_W'(FRAME_LO);
	localparam logic [DELAY_W-1:0] SETTLE_BASE_DEFAULT = 16'h0040;

	typedef struct packed {
		logic [STATUS_BITS-1:0]   status;
		logic [NUM_CH*RES_HI-1:0] samples;
	} conv_frame_s;

	typedef struct packed {
		logic       chain_en;
		logic       clk_out_en;
		logic [2:0] data_rate;
	} cfg_s;
endpackage : chain_pkg

// *** hw/sync2.sv ***
// Two-flop synchroniser for a bundle of independent level signals
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta_ff  <= '0;
			sync_out <= '0;
		end else begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : sync2
`default_nettype wire

// *** hw/chain_readout.sv ***
// Serial readout of one converter with optional daisy-chain pass-through
//
// Behaviour
// - Data output enable drops whenever chip select is high.
// - Chain input is used only when the chain enable bit is set.
// - In chain mode bits from the chain input leave on our data output.
// - Own frame first, then one don't-care bit, then downstream frames.
// - Frame is 8 channels times 16 or 24 bits plus 24 status bits.
// - Every device captures the same command bytes from shared data in.
// - Register readback is valid only from the device nearest the host.
// - Clock output enabled only with clock source pin at 1 and enable bit set.
// - Start rise to data-ready fall delay is fixed for a given data rate.
`timescale 1ns/1ps
`default_nettype none
module chain_readout #(
	parameter logic [chain_pkg::DELAY_W-1:0] SETTLE_BASE = chain_pkg::SETTLE_BASE_DEFAULT
) (
	input  wire logic                                clk_in,
	input  wire logic                                rst_in,
	input  wire logic                                sclk_in,
	input  wire logic                                cs_n_in,
	input  wire logic                                din_in,
	input  wire logic                                chain_in,
	input  wire logic                                start_in,
	input  wire logic                                clock_source_select_pin_in,
	input  wire logic                                start_cmd_in,
	input  wire chain_pkg::cfg_s                     cfg_in,
	input  wire chain_pkg::conv_frame_s              frame_in,
	input  wire logic                                reg_read_in,
	input  wire logic [chain_pkg::REG_BITS-1:0]      reg_data_in,
	output logic                                     dout_out,
	output logic                                     dout_oe_out,
	output logic                                     data_ready_n_out,
	output logic                                     clk_out_en_out,
	output logic [chain_pkg::CMD_BITS-1:0]           cmd_byte_out,
	output logic                                     cmd_valid_out,
	output logic [chain_pkg::BITS_W-1:0]             frame_bits_out
);
	localparam int TOP = chain_pkg::SR_LEN - 1;

	logic [4:0] pins_sync;
	logic       sclk_s;
	logic       cs_n_s;
	logic       din_s;
	logic       chain_s;
	logic       start_s;
	logic       clock_source_select_pin_s;
	logic       sclk_prev_ff;
	logic       cs_prev_ff;
	logic       start_prev_ff;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_fall;
	logic       start_rise;
	logic       hi_res;
	logic       cs_act_s;
	logic [chain_pkg::BITS_W-1:0] own_bits;
	chain_pkg::conv_frame_s        held_ff;

	// Chip select travels inverted so the cleared pair reads as deselected after reset
	sync2 #(.W(5)) u_sync (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.async_in({sclk_in, ~cs_n_in, din_in, chain_in, start_in}),
		.sync_out(pins_sync)
	);

	// Strap pin sampled through its own pair; its reset value is a constant
	sync2 #(.W(1)) u_sync_clock_source_select_pin (
		.clk_in  (clk_in),
		.rst_in  (rst_in),
		.async_in(clock_source_select_pin_in),
		.sync_out(clock_source_select_pin_s)
	);

	assign {sclk_s, cs_act_s, din_s, chain_s, start_s} = pins_sync;
	assign cs_n_s = ~cs_act_s;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sclk_prev_ff  <= 1'b0;
			cs_prev_ff    <= 1'b1;
			start_prev_ff <= 1'b0;
		end else begin
			sclk_prev_ff  <= sclk_s;
			cs_prev_ff    <= cs_n_s;
			start_prev_ff <= start_s;
		end
	end

	assign sclk_rise  = sclk_s & ~sclk_prev_ff & ~cs_n_s;
	assign sclk_fall  = ~sclk_s & sclk_prev_ff & ~cs_n_s;
	assign cs_fall    = ~cs_n_s & cs_prev_ff;
	assign start_rise = start_s & ~start_prev_ff;
	assign hi_res     = cfg_in.data_rate >= chain_pkg::DR_HI_RES_MIN;
	assign own_bits   = hi_res ? chain_pkg::FRAME_HI_BITS : chain_pkg::FRAME_LO_BITS;

	// Frame assembly: low resolution keeps the upper bits of each sample
	logic [chain_pkg::FRAME_HI-1:0] frame_hi;
	logic [chain_pkg::FRAME_LO-1:0] frame_lo;
	assign frame_hi = held_ff;
	assign frame_lo[chain_pkg::FRAME_LO-1 -: chain_pkg::STATUS_BITS] = held_ff.status;

	genvar ch;
	generate
		for (ch = 0; ch < chain_pkg::NUM_CH; ch++) begin : g_lo
			assign frame_lo[ch*chain_pkg::RES_LO +: chain_pkg::RES_LO] =
				held_ff.samples[ch*chain_pkg::RES_HI + chain_pkg::RES_HI - 1 -: chain_pkg::RES_LO];
		end
	endgenerate

	// Conversion timing and data ready
	logic [chain_pkg::DELAY_W-1:0] settle_cnt_ff;
	logic [chain_pkg::DELAY_W-1:0] settle_len;
	logic                          run_ff;
	logic                          conv_done;

	assign settle_len = SETTLE_BASE << cfg_in.data_rate;
	assign conv_done  = run_ff && (settle_cnt_ff == '0);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			run_ff        <= 1'b0;
			settle_cnt_ff <= '0;
		end else if (start_rise || start_cmd_in) begin
			// Restart always reloads the same count, so devices stay in step
			run_ff        <= 1'b1;
			settle_cnt_ff <= settle_len - 1'b1;
		end else if (conv_done) begin
			run_ff        <= start_s | ~start_prev_ff | run_ff;
			settle_cnt_ff <= settle_len - 1'b1;
		end else if (run_ff) begin
			settle_cnt_ff <= settle_cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			data_ready_n_out <= 1'b1;
			held_ff          <= '0;
		end else if (start_rise || start_cmd_in) begin
			data_ready_n_out <= 1'b1;
		end else if (conv_done) begin
			// A fresh result beats a read that opens in the same cycle
			data_ready_n_out <= 1'b0;
			held_ff          <= frame_in;
		end else if (cs_fall) begin
			data_ready_n_out <= 1'b1;
		end
	end

	// Output shift register: own frame, don't-care bit, then chain bits
	logic [TOP:0]                 sr_ff;
	logic [TOP:0]                 nxt_sr;
	logic [TOP:0]                 sr_load;
	logic [chain_pkg::BITS_W-1:0] ins_idx;
	logic                         chain_bit;
	logic [chain_pkg::FRAME_HI-1:0] held_hi;
	logic [chain_pkg::FRAME_LO-1:0] held_lo;

	assign held_hi   = frame_hi;
	assign held_lo   = frame_lo;
	assign chain_bit = cfg_in.chain_en & chain_s;
	assign ins_idx   = chain_pkg::BITS_W'(TOP) - own_bits;

	always_comb begin
		if (reg_read_in) begin
			sr_load = {reg_data_in, {(chain_pkg::SR_LEN - chain_pkg::REG_BITS){1'b0}}};
		end else if (hi_res) begin
			sr_load = {held_hi, 1'b0};
		end else begin
			sr_load = {held_lo, {(chain_pkg::SR_LEN - chain_pkg::FRAME_LO){1'b0}}};
		end
	end

	always_comb begin
		nxt_sr          = {sr_ff[TOP-1:0], 1'b0};
		nxt_sr[ins_idx] = chain_bit;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sr_ff    <= '0;
			dout_out <= 1'b0;
		end else if (cs_fall) begin
			sr_ff    <= sr_load;
			dout_out <= sr_load[TOP];
		end else if (sclk_rise) begin
			dout_out <= sr_ff[TOP];
		end else if (sclk_fall) begin
			// Chain bit taken on the falling edge leaves 217 rising edges later at full resolution, 153 at low resolution
			sr_ff    <= nxt_sr;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			dout_oe_out <= 1'b0;
		end else begin
			dout_oe_out <= ~cs_n_s;
		end
	end

	// Command capture happens in every device regardless of chain position
	logic [chain_pkg::CMD_BITS-1:0] cmd_sr_ff;
	logic [2:0]                     cmd_cnt_ff;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cmd_sr_ff     <= '0;
			cmd_cnt_ff    <= '0;
			cmd_byte_out  <= '0;
			cmd_valid_out <= 1'b0;
		end else begin
			cmd_valid_out <= 1'b0;
			if (cs_n_s) begin
				cmd_cnt_ff <= '0;
			end else if (sclk_fall) begin
				cmd_sr_ff  <= {cmd_sr_ff[chain_pkg::CMD_BITS-2:0], din_s};
				cmd_cnt_ff <= cmd_cnt_ff + 3'h1;
				if (cmd_cnt_ff == 3'h7) begin
					cmd_byte_out  <= {cmd_sr_ff[chain_pkg::CMD_BITS-2:0], din_s};
					cmd_valid_out <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			clk_out_en_out <= 1'b0;
			frame_bits_out <= chain_pkg::FRAME_LO_BITS;
		end else begin
			// Oscillator sharing is meaningless in a chain, so it is held off
			clk_out_en_out <= clock_source_select_pin_s & cfg_in.clk_out_en & ~cfg_in.chain_en;
			frame_bits_out <= own_bits;
		end
	end
endmodule : chain_readout
`default_nettype wire

// *** bench/chain_checker.sv ***
// Port assertions for the chain readout block
`timescale 1ns/1ps
`default_nettype none
module chain_checker #(
	parameter logic [chain_pkg::DELAY_W-1:0] SETTLE_BASE = chain_pkg::SETTLE_BASE_DEFAULT
) (
	input wire logic            clk_in,
	input wire logic            rst_in,
	input wire logic            cs_n_in,
	input wire logic            start_cmd_in,
	input wire logic            clock_source_select_pin_in,
	input wire chain_pkg::cfg_s cfg_in,
	input wire logic            dout_oe_out,
	input wire logic            data_ready_n_out,
	input wire logic            clk_out_en_out,
	input wire logic            cmd_valid_out,
	input wire logic [7:0]      frame_bits_out
);
	logic [15:0] wait_ff;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Saturates so a long run never wraps into a false short settle
	always_ff @(posedge clk_in) begin
		if (rst_in || start_cmd_in)
			wait_ff <= 16'h0000;
		else if (wait_ff != 16'hffff)
			wait_ff <= wait_ff + 16'h0001;
	end
	oe_release_a: assert property (cs_n_in [*4] |-> !dout_oe_out)
		else $error("data output driven while deselected");
	oe_cause_a: assert property ($rose(dout_oe_out) |-> !$past(cs_n_in, 3))
		else $error("data output enabled without chip select");
	clk_cfg_a: assert property (clk_out_en_out |->
		$past(cfg_in.clk_out_en) && !$past(cfg_in.chain_en))
		else $error("clock output enabled against configuration");
	clk_pin_a: assert property ($rose(clk_out_en_out) |->
		$past(clock_source_select_pin_in, 3))
		else $error("clock output enabled with external clock source");
	frame_len_a: assert property ((!rst_in && $stable(cfg_in.data_rate)) [*3] |->
		frame_bits_out == (cfg_in.data_rate >= chain_pkg::DR_HI_RES_MIN ? 8'hd8 : 8'h98))
		else $error("frame length does not match data rate");
	cmd_pulse_a: assert property (cmd_valid_out |=> !cmd_valid_out)
		else $error("command strobe longer than one cycle");
	cmd_cs_a: assert property (cmd_valid_out |-> !$past(cs_n_in, 3))
		else $error("command taken while deselected");
	settle_a: assert property ($fell(data_ready_n_out) && cfg_in.data_rate == 3'h0 |->
		wait_ff >= SETTLE_BASE - 16'h0001 && wait_ff <= SETTLE_BASE + 16'h0001)
		else $error("start to data ready delay off");
	ready_hold_a: assert property (start_cmd_in |-> ##2 data_ready_n_out [*2])
		else $error("data ready low during settling");
	cover property ($rose(dout_oe_out) && cfg_in.chain_en);
	cover property (cmd_valid_out);
	cover property ($fell(data_ready_n_out));
endmodule : chain_checker
bind chain_readout chain_checker #(.SETTLE_BASE(SETTLE_BASE)) chain_checker_inst (.*);
`default_nettype wire

// *** bench/chain_host.sv ***
// Host serial master with a downstream chained device stand-in
`timescale 1ns/1ps
`default_nettype none
module chain_host (
	input  wire logic clk_in,
	input  wire logic dout_in,
	output logic      sclk_out,
	output logic      cs_n_out,
	output logic      din_out,
	output logic      chain_out
);
	// A single downstream device keeps the chain well inside what the serial clock allows
	logic [23:0]  down_word;
	logic [511:0] rx;
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		din_out = 1'b0;
		chain_out = 1'b0;
		down_word = 24'hc35a96;
	end
	// Samples just before each fall, once the rise has moved the data output
	// Command byte repeats so every completed byte on data in is the same
	task automatic xfer(input int nb, input logic [7:0] cmd);
		cs_n_out = 1'b0;
		chain_out = down_word[23];
		repeat (6) @(negedge clk_in);
		for (int i = 0; i < nb; i++) begin // One extra clock between data sets is in nb
			din_out = cmd[7 - (i % 8)];
			sclk_out = 1'b1;
			chain_out = down_word[23 - (i % 24)];
			repeat (4) @(negedge clk_in);
			rx = {rx[510:0], dout_in};
			sclk_out = 1'b0;
			repeat (4) @(negedge clk_in);
		end
		cs_n_out = 1'b1;
		chain_out = 1'b0;
		din_out = 1'b0;
		// Deselect must pass the synchronisers before the next frame opens
		repeat (4) @(negedge clk_in);
	endtask : xfer
endmodule : chain_host
`default_nettype wire

// *** bench/chain_readout_bench.sv ***
// Self-checking bench for the chain readout block
`timescale 1ns/1ps
`default_nettype none
module chain_readout_bench;
	logic                   clk_in, rst_in, sclk_in, cs_n_in, din_in, chain_in, start_in;
	logic                   clock_source_select_pin_in, start_cmd_in, reg_read_in;
	logic                   dout_out, dout_oe_out, data_ready_n_out, clk_out_en_out, cmd_valid_out;
	logic [7:0]             reg_data_in, cmd_byte_out, frame_bits_out, last_cmd;
	logic [255:0]           want;
	chain_pkg::cfg_s        cfg_in;
	chain_pkg::conv_frame_s frame_in;
	int                     n_errors, check_count, cycles, n0, n1, pa, pb;
	chain_readout #(.SETTLE_BASE(16'h0004)) chain_readout_inst (.*);
	chain_host chain_host_inst (.clk_in, .dout_in(dout_out), .sclk_out(sclk_in),
		.cs_n_out(cs_n_in), .din_out(din_in), .chain_out(chain_in));
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cmd_valid_out === 1'b1)
			last_cmd <= cmd_byte_out;
		if (cycles == 10000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic check(input logic [255:0] got, input logic [255:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask : check
	// Counts cycles from the start request until data ready has risen and fallen again
	task automatic meas(input logic [2:0] dr, input logic pin, output int n);
		bit seen = 1'b0;
		repeat (2) @(negedge clk_in);
		cfg_in.data_rate = dr;
		start_in = pin;
		start_cmd_in = !pin;
		@(negedge clk_in);
		start_cmd_in = 1'b0;
		n = 0;
		while (!(seen && data_ready_n_out === 1'b0) && n < 500) begin
			@(negedge clk_in);
			n++;
			seen = seen || data_ready_n_out === 1'b1;
		end
		start_in = 1'b0;
	endtask : meas
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run
	initial begin
		rst_in = 1'b1;
		start_in = 1'b0;
		start_cmd_in = 1'b0;
		clock_source_select_pin_in = 1'b0;
		reg_read_in = 1'b0;
		reg_data_in = 8'h3c;
		cfg_in = '0;
		frame_in.status = 24'ha1b2c3;
		for (int c = 0; c < 8; c++)
			frame_in.samples[c*24 +: 24] = {4'(c), 4'h9, 8'h5c ^ 8'(c), 8'h3a};
		repeat (20) @(negedge clk_in);
		rst_in = 1'b0;
		for (int d = 0; d < 8; d++) begin
			cfg_in.data_rate = 3'(d);
			repeat (4) @(negedge clk_in);
			check(256'(frame_bits_out), (d >= 2) ? 256'hd8 : 256'h98);
		end
		for (int k = 0; k < 8; k++) begin
			{clock_source_select_pin_in, cfg_in.clk_out_en, cfg_in.chain_en} = 3'(k);
			repeat (5) @(negedge clk_in);
			check(256'(clk_out_en_out), 256'(k == 6));
		end
		cfg_in = '0;
		clock_source_select_pin_in = 1'b0;
		meas(3'h0, 1'b0, n0);
		meas(3'h1, 1'b0, n1);
		check(256'(n1 - n0), 256'h4);
		meas(3'h2, 1'b1, pa);
		meas(3'h2, 1'b1, pb);
		check(256'(pa), 256'(pb));
		meas(3'h2, 1'b0, n1);
		check(256'(n1 - n0), 256'hc);
		chain_host_inst.xfer(225, 8'ha5);
		check(256'(chain_host_inst.rx[224:9]), 256'(frame_in));
		check(256'(chain_host_inst.rx[7:0]), 256'h0);
		check(256'(last_cmd), 256'ha5);
		cfg_in.chain_en = 1'b1;
		meas(3'h1, 1'b0, n1);
		want = '0;
		want[151:128] = frame_in.status;
		for (int c = 0; c < 8; c++)
			want[c*16 +: 16] = frame_in.samples[c*24+8 +: 16];
		chain_host_inst.xfer(177, 8'h00);
		check(256'(chain_host_inst.rx[176:25]), want);
		check(256'(chain_host_inst.rx[23:0]), 256'(chain_host_inst.down_word));
		reg_read_in = 1'b1;
		chain_host_inst.xfer(16, 8'h69);
		check(256'(chain_host_inst.rx[15:0]), 256'h3c00);
		check(256'(last_cmd), 256'h69);
		repeat (6) @(negedge clk_in);
		check(256'(dout_oe_out), 256'h0);
		complete_run();
	end
endmodule : chain_readout_bench
`default_nettype wire
